// File: rtl/edfd_pkg.sv
// Constants, register map and types shared by the Ethernet DMA engine.
package edfd_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_REQUEST = 8'h04;
   localparam logic [7:0] OFS_EVENT = 8'h08;
   localparam logic [7:0] OFS_TX_LIST = 8'h0c;
   localparam logic [7:0] OFS_RX_LIST = 8'h10;
   localparam logic [7:0] OFS_FIFO_DEPTH = 8'h14;
   localparam logic [7:0] OFS_FLOW_THRESH = 8'h18;
   localparam logic [7:0] OFS_TX_NOTIFY = 8'h1c;
   localparam logic [7:0] OFS_CUR_DESC = 8'h20;
   // Field positions.
   localparam int FRAME_FIELD_LSB = 16;
   localparam int EV_TWB_BIT = 0;
   localparam int EV_RX_FRAME_BIT = 1;
   localparam int EV_TX_STOP_BIT = 2;
   localparam int EV_RX_STOP_BIT = 3;
   localparam int DESC_ACTIVE_BIT = 31;
   localparam int DESC_LIST_END_BIT = 30;
   localparam int DESC_FRAME_END_BIT = 28;
   // Reset values.
   localparam logic [2:0] FRAME_FIELD_RESET = 3'h7;
   localparam logic [2:0] BYTE_FIELD_RESET = 3'h0;
   localparam logic [1:0] MODE_RESET = 2'h0;
   // Byte threshold and descriptor step arithmetic.
   localparam logic [11:0] BASE_DEPTH = 12'h100;
   localparam logic [11:0] HEADROOM = 12'h040;
   localparam logic [3:0] DESC_BASE_STEP = 4'h4;
   // Engine states.
   typedef enum logic [2:0] {
      ST_IDLE, ST_DESC, ST_TX_READ, ST_TX_SEND, ST_RX_TAKE, ST_RX_WRITE, ST_WBACK
   } edfd_state_type;
endpackage

// File: rtl/edfd_dma.sv
// Ethernet DMA engine with descriptor lists, flow-control threshold and notify mode.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module edfd_dma
   import edfd_pkg::*;
#(
   parameter bit LARGE_FIFO = 1'b0
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [31:0] mem_address,
   output logic mem_read,
   output logic mem_write,
   output logic [31:0] mem_writedata,
   output logic [3:0] mem_byteenable,
   input wire logic [31:0] mem_readdata,
   input wire logic mem_waitrequest,
   output logic [7:0] tx_data,
   output logic tx_valid,
   output logic tx_last,
   input wire logic tx_ready,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_last,
   output logic rx_ready,
   input wire logic [11:0] rx_fifo_bytes,
   input wire logic [3:0] rx_fifo_frames,
   output logic flow_request
);

   // Merge a bus write into a register under its byte enables.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Receive FIFO size in bytes for a depth code.
   function automatic logic [11:0] depth_bytes(input logic [2:0] code);
      return BASE_DEPTH << code;
   endfunction

   logic rst_q1, rst_q2, bus_ack, notify, chan, frame_end, wr_hit, mem_ack, last_of_buf;
   logic [1:0] desc_size, go, widx, go_clr;
   logic [2:0] depth_code, byte_code, frame_code;
   logic [3:0] events, ev_set;
   logic [7:0] rx_byte;
   logic [15:0] blen, cnt;
   logic [31:0] tx_list, rx_list, tx_desc, rx_desc, dw0, bptr, cur_desc, buf_addr, desc_step;
   logic [31:0] wb_word;
   edfd_state_type state;

   // Reset is released through two flops so every flop leaves reset on one edge.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end

   // Every access waits one cycle, so read data always come from a flop.
   assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
   assign wr_hit = avs_write && bus_ack;

   always_ff @(posedge clock or negedge rst_q2) begin
      if (!rst_q2) begin
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= (avs_read || avs_write) && !bus_ack;
      end
   end

   // Read mux; unmapped offsets read as zero.
   always_ff @(posedge clock or negedge rst_q2) begin
      if (!rst_q2) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !bus_ack) begin
         unique case (avs_address)
            OFS_MODE: avs_readdata <= {30'h0, desc_size};
            OFS_REQUEST: avs_readdata <= {30'h0, go};
            OFS_EVENT: avs_readdata <= {28'h0, events};
            OFS_TX_LIST: avs_readdata <= tx_list;
            OFS_RX_LIST: avs_readdata <= rx_list;
            OFS_FIFO_DEPTH: avs_readdata <= {29'h0, depth_code};
            OFS_FLOW_THRESH: avs_readdata <= {13'h0, frame_code, 13'h0, byte_code};
            OFS_TX_NOTIFY: avs_readdata <= {31'h0, notify};
            OFS_CUR_DESC: avs_readdata <= cur_desc;
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   // Plain configuration registers written by software.
   always_ff @(posedge clock or negedge rst_q2) begin
      if (!rst_q2) begin
         desc_size <= MODE_RESET;
         tx_list <= 32'h0;
         rx_list <= 32'h0;
         depth_code <= BYTE_FIELD_RESET;
         notify <= 1'b0;
         frame_code <= FRAME_FIELD_RESET;
      end else if (wr_hit) begin
         unique case (avs_address)
            OFS_MODE: desc_size <= avs_byteenable[0] ? avs_writedata[1:0] : desc_size;
            OFS_TX_LIST: tx_list <= merge(tx_list, avs_writedata, avs_byteenable);
            OFS_RX_LIST: rx_list <= merge(rx_list, avs_writedata, avs_byteenable);
            OFS_FIFO_DEPTH: begin
               if (avs_byteenable[0] && (avs_writedata[2:0] == 3'h0 ||
                   (LARGE_FIFO && avs_writedata[2:0] == 3'h1))) begin
                  depth_code <= avs_writedata[2:0];
               end
            end
            OFS_FLOW_THRESH: begin
               if (avs_byteenable[2]) begin
                  frame_code <= avs_writedata[FRAME_FIELD_LSB +: 3];
               end
            end
            OFS_TX_NOTIFY: begin
               if (avs_byteenable[0]) begin
                  notify <= avs_writedata[0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Byte code: prohibited codes are not stored; one above the depth code is not caught.
   always_ff @(posedge clock or negedge rst_q2) begin
      if (!rst_q2) begin
         byte_code <= BYTE_FIELD_RESET;
      end else if (wr_hit && avs_address == OFS_FLOW_THRESH && avs_byteenable[0]) begin
         if (avs_writedata[2:0] == 3'h0 || (LARGE_FIFO && avs_writedata[2:0] == 3'h1)) begin
            byte_code <= avs_writedata[2:0];
         end
      end
   end

   // Pause request: either threshold alone raises it, and it falls when both clear.
   always_ff @(posedge clock or negedge rst_q2) begin
      if (!rst_q2) begin
         flow_request <= 1'b0;
      end else begin
         flow_request <= (rx_fifo_bytes >= depth_bytes(byte_code) - HEADROOM) ||
                         (rx_fifo_frames >= {1'b0, frame_code} + 4'h1);
      end
   end

   // Channel run bits; a software start beats a stop in the same cycle.
   always_ff @(posedge clock or negedge rst_q2) begin
      if (!rst_q2) begin
         go <= 2'h0;
      end else begin
         go <= (go & ~go_clr) |
               ((wr_hit && avs_address == OFS_REQUEST && avs_byteenable[0]) ?
                avs_writedata[1:0] : 2'h0);
      end
   end

   // Sticky event flags, write one to clear; a new event wins over the clear.
   always_ff @(posedge clock or negedge rst_q2) begin
      if (!rst_q2) begin
         events <= 4'h0;
      end else begin
         events <= (events & ~((wr_hit && avs_address == OFS_EVENT && avs_byteenable[0]) ?
                    avs_writedata[3:0] : 4'h0)) | ev_set;
      end
   end

   // Memory side helpers.
   assign mem_ack = (mem_read || mem_write) && !mem_waitrequest;
   assign cur_desc = chan ? rx_desc : tx_desc;
   assign buf_addr = bptr + {16'h0, cnt};
   assign desc_step = {26'h0, DESC_BASE_STEP, 2'h0} << desc_size;
   assign last_of_buf = (cnt + 16'h1) == blen;
   assign wb_word = chan ? {1'b0, dw0[30:29], frame_end, dw0[27:16], cnt + 16'h1} :
                    {1'b0, dw0[30:0]};

   // Bus requests follow the state; they hold until the memory accepts them.
   assign mem_read = (state == ST_DESC) || (state == ST_TX_READ);
   assign mem_write = (state == ST_RX_WRITE) || (state == ST_WBACK);
   assign tx_valid = state == ST_TX_SEND;
   assign rx_ready = state == ST_RX_TAKE;

   always_comb begin
      mem_address = 32'h0;
      mem_writedata = 32'h0;
      mem_byteenable = 4'hf;
      unique case (state)
         ST_DESC: mem_address = cur_desc + {28'h0, widx, 2'h0};
         ST_TX_READ: mem_address = {buf_addr[31:2], 2'h0};
         ST_RX_WRITE: begin
            mem_address = {buf_addr[31:2], 2'h0};
            mem_writedata = {4{rx_byte}};
            mem_byteenable = 4'h1 << buf_addr[1:0];
         end
         ST_WBACK: begin
            mem_address = cur_desc;
            mem_writedata = wb_word;
         end
         default: begin
         end
      endcase
   end

   // Event and stop pulses raised by the engine.
   always_comb begin
      ev_set = 4'h0;
      go_clr = 2'h0;
      if (state == ST_DESC && mem_ack && widx == 2'h0 && !mem_readdata[DESC_ACTIVE_BIT]) begin
         go_clr[chan] = 1'b1;
         ev_set[chan ? EV_RX_STOP_BIT : EV_TX_STOP_BIT] = 1'b1;
      end
      if (state == ST_WBACK && mem_ack) begin
         ev_set[EV_TWB_BIT] = !chan && notify && dw0[DESC_FRAME_END_BIT];
         ev_set[EV_RX_FRAME_BIT] = chan && frame_end;
      end
   end

   // Descriptor pointers step through the list and wrap at the list end.
   always_ff @(posedge clock or negedge rst_q2) begin
      if (!rst_q2) begin
         tx_desc <= 32'h0;
         rx_desc <= 32'h0;
      end else begin
         if (state == ST_WBACK && mem_ack) begin
            if (chan) begin
               rx_desc <= dw0[DESC_LIST_END_BIT] ? rx_list : rx_desc + desc_step;
            end else begin
               tx_desc <= dw0[DESC_LIST_END_BIT] ? tx_list : tx_desc + desc_step;
            end
         end
         if (wr_hit && avs_address == OFS_REQUEST && avs_byteenable[0]) begin
            if (avs_writedata[0] && !go[0]) begin
               tx_desc <= tx_list;
            end
            if (avs_writedata[1] && !go[1]) begin
               rx_desc <= rx_list;
            end
         end
      end
   end

   // Transfer engine; channels alternate so neither starves the other.
   always_ff @(posedge clock or negedge rst_q2) begin
      if (!rst_q2) begin
         state <= ST_IDLE;
         chan <= 1'b0;
         widx <= 2'h0;
         dw0 <= 32'h0;
         blen <= 16'h0;
         bptr <= 32'h0;
         cnt <= 16'h0;
         frame_end <= 1'b0;
         rx_byte <= 8'h0;
         tx_data <= 8'h0;
         tx_last <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               widx <= 2'h0;
               if (go[1] && (chan == 1'b1 || !go[0])) begin
                  chan <= 1'b1;
                  state <= ST_DESC;
               end else if (go[0]) begin
                  chan <= 1'b0;
                  state <= ST_DESC;
               end
            end
            ST_DESC: begin
               if (mem_ack) begin
                  widx <= widx + 2'h1;
                  unique case (widx)
                     2'h0: dw0 <= mem_readdata;
                     2'h1: blen <= mem_readdata[15:0];
                     default: bptr <= mem_readdata;
                  endcase
                  cnt <= 16'h0;
                  frame_end <= 1'b0;
                  if (widx == 2'h0 && !mem_readdata[DESC_ACTIVE_BIT]) begin
                     state <= ST_IDLE;
                  end else if (widx == 2'h2) begin
                     if (blen == 16'h0) begin
                        state <= ST_WBACK;
                     end else begin
                        state <= chan ? ST_RX_TAKE : ST_TX_READ;
                     end
                  end
               end
            end
            ST_TX_READ: begin
               if (mem_ack) begin
                  tx_data <= mem_readdata[8*buf_addr[1:0] +: 8];
                  tx_last <= last_of_buf && dw0[DESC_FRAME_END_BIT];
                  state <= ST_TX_SEND;
               end
            end
            ST_TX_SEND: begin
               if (tx_ready) begin
                  cnt <= cnt + 16'h1;
                  state <= last_of_buf ? ST_WBACK : ST_TX_READ;
               end
            end
            ST_RX_TAKE: begin
               if (rx_valid) begin
                  rx_byte <= rx_data;
                  frame_end <= rx_last;
                  state <= ST_RX_WRITE;
               end
            end
            ST_RX_WRITE: begin
               if (mem_ack) begin
                  if (frame_end || last_of_buf) begin
                     state <= ST_WBACK;
                  end else begin
                     cnt <= cnt + 16'h1;
                     state <= ST_RX_TAKE;
                  end
               end
            end
            ST_WBACK: begin
               if (mem_ack) begin
                  chan <= !chan;
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

endmodule

// File: testbench/edfd_dma_assertions.sv
// Port-level checks on the DMA engine: flow request, bus answer, held requests.
`timescale 1ns/10ps
module edfd_dma_assertions #(
   parameter bit LARGE_FIFO = 1'b0
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [31:0] mem_address,
   input wire logic mem_read,
   input wire logic mem_write,
   input wire logic [31:0] mem_writedata,
   input wire logic [3:0] mem_byteenable,
   input wire logic mem_waitrequest,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_last,
   input wire logic tx_ready,
   input wire logic [11:0] rx_fifo_bytes,
   input wire logic [3:0] rx_fifo_frames,
   input wire logic flow_request
);
   // A fill this large trips flow control under every legal byte code.
   localparam int BYTE_TRIP = LARGE_FIFO ? 448 : 192;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_bus_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_mem_stall;
      (mem_read || mem_write) && mem_waitrequest;
   endsequence
   byte_flow_a: assert property (rx_fifo_bytes >= BYTE_TRIP |=> flow_request)
      else $error("Flow request missing at byte fill.");
   frame_flow_a: assert property (rx_fifo_frames >= 4'h8 |=> flow_request)
      else $error("Flow request missing at eight frames.");
   flow_drop_a: assert property (rx_fifo_bytes < 12'h0c0 && rx_fifo_frames == 4'h0
      |=> !flow_request) else $error("Flow request held with no cause.");
   bus_answer_a: assert property ($rose(avs_read || avs_write)
      |-> s_bus_wait ##1 !avs_waitrequest) else $error("Bus answer not after one wait.");
   idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("Wait raised with no request.");
   mem_hold_a: assert property (s_mem_stall |=> $stable(mem_address)
      && $stable(mem_read) && $stable(mem_write)) else $error("Memory request moved.");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid
      && $stable(tx_data) && $stable(tx_last)) else $error("Transmit byte moved.");
   rx_lane_a: assert property (mem_write && mem_byteenable != 4'hf |->
      $onehot(mem_byteenable) && mem_writedata == {4{mem_writedata[7:0]}})
      else $error("Receive byte write malformed.");
endmodule
bind edfd_dma edfd_dma_assertions #(.LARGE_FIFO(LARGE_FIFO)) edfd_dma_assertions_inst (.clock,
   .rstn, .avs_read, .avs_write, .avs_waitrequest, .mem_address, .mem_read, .mem_write,
   .mem_writedata, .mem_byteenable, .mem_waitrequest, .tx_data, .tx_valid, .tx_last,
   .tx_ready, .rx_fifo_bytes, .rx_fifo_frames, .flow_request);

// File: testbench/edfd_far_model.sv
// Memory and MAC stand-in on the far side of the DMA engine.
`timescale 1ns/10ps
module edfd_far_model (
   input wire logic clock,
   input wire logic slow,
   input wire logic [31:0] mem_address,
   input wire logic mem_read,
   input wire logic mem_write,
   input wire logic [31:0] mem_writedata,
   input wire logic [3:0] mem_byteenable,
   output logic [31:0] mem_readdata,
   output logic mem_waitrequest,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_last,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_last,
   input wire logic rx_ready
);
   logic [31:0] mem [0:63];
   logic [8:0] txq [$];
   logic [7:0] cnt = 8'h00;
   int ri = 0;
   int rx_n = 0;
   // Slow mode stalls memory on alternate cycles and transmit two cycles in four, so held requests really get tested.
   assign mem_waitrequest = slow & cnt[0];
   assign tx_ready = ~(slow & cnt[1]);
   // Outside an accepted read the data lines show a moving pattern, not the last word.
   assign mem_readdata = (mem_read & ~mem_waitrequest) ? mem[mem_address[7:2]] : {4{cnt}};
   assign rx_valid = ri < rx_n;
   assign rx_data = rx_valid ? 8'ha1 + ri[7:0] : cnt;
   assign rx_last = rx_valid && ri == rx_n - 1;
   // Byte-lane memory writes, transmit capture and receive stepping.
   always @(posedge clock) begin
      cnt <= cnt + 8'h01;
      if (mem_write & ~mem_waitrequest) begin
         for (int b = 0; b < 4; b++) begin
            if (mem_byteenable[b]) mem[mem_address[7:2]][8*b +: 8] <= mem_writedata[8*b +: 8];
         end
      end
      if (tx_valid & tx_ready) txq.push_back({tx_last, tx_data});
      if (rx_valid & rx_ready) ri <= ri + 1;
   end
endmodule

// File: testbench/edfd_dma_tb.sv
// Self-checking bench for the Ethernet DMA engine.
`timescale 1ns/10ps
module edfd_dma_tb
   import edfd_pkg::*;
;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic slow = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [11:0] rx_fifo_bytes = 12'h000;
   logic [3:0] rx_fifo_frames = 4'h0;
   logic [31:0] avs_readdata, mem_address, mem_writedata, mem_readdata;
   logic avs_waitrequest, mem_read, mem_write, mem_waitrequest;
   logic [3:0] mem_byteenable;
   logic [7:0] tx_data, rx_data;
   logic tx_valid, tx_last, tx_ready, rx_valid, rx_last, rx_ready, flow_request;
   int n_mismatch = 0;
   int num_checks = 0;
   edfd_dma edfd_dma_inst (.clock, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_address, .mem_read, .mem_write,
      .mem_writedata, .mem_byteenable, .mem_readdata, .mem_waitrequest, .tx_data, .tx_valid,
      .tx_last, .tx_ready, .rx_data, .rx_valid, .rx_last, .rx_ready, .rx_fifo_bytes,
      .rx_fifo_frames, .flow_request);
   edfd_far_model edfd_far_model_inst (.clock, .slow, .mem_address, .mem_read, .mem_write,
      .mem_writedata, .mem_byteenable, .mem_readdata, .mem_waitrequest, .tx_data, .tx_valid,
      .tx_last, .tx_ready, .rx_data, .rx_valid, .rx_last, .rx_ready);
   // Fifty megahertz system clock.
   initial forever #10 clock = ~clock;
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic ok, input string what);
      num_checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask
   // One bus cycle; the request is held until waitrequest is seen low at a rising edge,
   // and read data are taken at that same edge.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q === e, "register read");
   endtask
   task automatic wait_ev(input int b, output logic [31:0] q);
      do bus(1'b0, OFS_EVENT, 32'h0, q); while (q[b] !== 1'b1);
   endtask
   task automatic flow_is(input logic [11:0] b, input logic [3:0] f, input logic e);
      @(posedge clock);
      rx_fifo_bytes <= b;
      rx_fifo_frames <= f;
      repeat (3) @(negedge clock);
      check(flow_request === e, "flow request level");
   endtask
   // Reset values, a refused byte code, then each frame code at its boundary.
   task automatic test_flow;
      logic [31:0] q;
      rd(OFS_FLOW_THRESH, 32'h00070000);
      rd(OFS_TX_NOTIFY, 32'h0);
      rd(8'h3c, 32'h0);
      rd(OFS_MODE, 32'h0);
      bus(1'b1, OFS_FLOW_THRESH, 32'h00070001, q);
      rd(OFS_FLOW_THRESH, 32'h00070000);
      flow_is(12'h0bf, 4'h0, 1'b0);
      flow_is(12'h0c0, 4'h0, 1'b1);
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, OFS_FLOW_THRESH, 32'(c) << 16, q);
         flow_is(12'h000, 4'(c), 1'b0);
         flow_is(12'h0c0, 4'(c), 1'b1);
         flow_is(12'h000, 4'(c + 1), 1'b1);
      end
      flow_is(12'h000, 4'h0, 1'b0);
   endtask
   // A frame split over two descriptors, the first buffer on an odd byte; the slow
   // run also selects the larger descriptor size, so the second descriptor moves.
   task automatic test_tx(input logic note, input logic sl);
      logic [31:0] q;
      logic [8:0] exp [3] = '{9'h022, 9'h033, 9'h155};
      int nx = sl ? 8 : 4;
      slow <= sl;
      edfd_far_model_inst.mem[0] = 32'h80000000;
      edfd_far_model_inst.mem[1] = 32'h2;
      edfd_far_model_inst.mem[2] = 32'h81;
      edfd_far_model_inst.mem[nx] = 32'hd0000000;
      edfd_far_model_inst.mem[nx + 1] = 32'h1;
      edfd_far_model_inst.mem[nx + 2] = 32'h84;
      edfd_far_model_inst.mem[32] = 32'h44332211;
      edfd_far_model_inst.mem[33] = 32'h55;
      edfd_far_model_inst.txq.delete();
      bus(1'b1, OFS_TX_NOTIFY, {31'h0, note}, q);
      bus(1'b1, OFS_EVENT, 32'hf, q);
      bus(1'b1, OFS_MODE, {31'h0, sl}, q);
      bus(1'b1, OFS_TX_LIST, 32'h0, q);
      bus(1'b1, OFS_REQUEST, 32'h1, q);
      wait_ev(EV_TX_STOP_BIT, q);
      check(q[EV_TWB_BIT] === note, "tx notify flag");
      check(edfd_far_model_inst.txq.size() == 3, "tx byte count");
      for (int i = 0; i < 3; i++) begin
         check(edfd_far_model_inst.txq[i] === exp[i], "tx byte");
      end
      check(edfd_far_model_inst.mem[nx] === 32'h50000000, "tx write-back");
   endtask
   // A three-byte frame into an aligned receive buffer.
   task automatic test_rx;
      logic [31:0] q;
      slow <= 1'b0;
      edfd_far_model_inst.mem[16] = 32'hc0000000;
      edfd_far_model_inst.mem[17] = 32'h10;
      edfd_far_model_inst.mem[18] = 32'ha0;
      edfd_far_model_inst.mem[40] = 32'h0;
      edfd_far_model_inst.rx_n = 3;
      bus(1'b1, OFS_EVENT, 32'hf, q);
      bus(1'b1, OFS_RX_LIST, 32'h40, q);
      bus(1'b1, OFS_REQUEST, 32'h2, q);
      wait_ev(EV_RX_STOP_BIT, q);
      check(q[EV_RX_FRAME_BIT] === 1'b1, "rx frame event");
      check(edfd_far_model_inst.mem[40] === 32'h00a3a2a1, "rx buffer bytes");
      check(edfd_far_model_inst.mem[16] === 32'h50000003, "rx write-back");
   endtask
   // Main sequence after a twelve-cycle reset.
   initial begin
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      repeat (4) @(posedge clock);
      test_flow();
      test_tx(1'b1, 1'b0);
      test_tx(1'b0, 1'b1);
      test_rx();
      tally_and_finish();
   end
   // Cuts a hang short; the whole sequence needs far fewer cycles.
   initial begin
      repeat (40000) @(posedge clock);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
